// [verilog/vrc_pkg.sv]
// How it works
// - down ramp: full rate, then quarter rate over the down offset
// - down offset codes 0, 5, 10, 20 mV
// - up offset first step, dropped at target
// - up offset codes 0, 5, 10, 20 mV
// - offsets only for fast or slow slews
// - protected writes nacked after power-on
// - every read acknowledged with data
// - full passcode sequence unlocks writes
// - lock write while unlocked relocks
// - power cycle relocks; restore keeps lock
// - lock register writes always nacked
// - fault_clear_command and lock register unguarded
// - sense code sets gain, scale, step
// - fixed overvoltage armed from reset release
// - overvoltage latches high off, low on
// - limit bit 2 set disables overvoltage
// - threshold from select bit and step
// - negative current limits halve at low setting
// - two user storage fields, rest zero
// - status mirror copies bus status bits
// - reserved bits read zero, unwritable
package vrc_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_FAULT_CLEAR_COMMAND  = 8'h03;
   localparam logic [7:0] ADDR_OFFSET_CFG    = 8'hb0;
   localparam logic [7:0] ADDR_LOCK          = 8'hb1;
   localparam logic [7:0] ADDR_SENSE_CFG     = 8'hb3;
   localparam logic [7:0] ADDR_LIMIT_CFG     = 8'hb4;
   localparam logic [7:0] ADDR_USER_A        = 8'hb5;
   localparam logic [7:0] ADDR_USER_B        = 8'hb6;
   localparam logic [7:0] ADDR_MIRROR        = 8'hba;

   localparam logic [7:0] MASK_OFFSET_CFG    = 8'h0f;
   localparam logic [7:0] MASK_SENSE_CFG     = 8'h07;
   localparam logic [7:0] MASK_LIMIT_CFG     = 8'h0f;
   localparam logic [7:0] MASK_USER_A        = 8'hf0;
   localparam logic [7:0] MASK_USER_B        = 8'he0;
   localparam logic [7:0] MASK_MIRROR        = 8'h8f;
   localparam logic [7:0] RESET_REG          = 8'h00;

   localparam int OFS_UP_LSB      = 0;
   localparam int OFS_DN_LSB      = 2;
   localparam int NOC_SEL_LSB     = 0;
   localparam int OVF_DIS_BIT     = 2;
   localparam int OVF_SEL_BIT     = 3;

   // ------------------------------------------------------------
   // passcodes (values arbitrary)
   // ------------------------------------------------------------
   localparam int          PASS_N     = 3;
   localparam logic [1:0]  PASS_LAST  = 2'h2;
   localparam logic [7:0]  PASS_CODE0 = 8'h5a;
   localparam logic [7:0]  PASS_CODE1 = 8'hc3;
   localparam logic [7:0]  PASS_CODE2 = 8'h96;

   // ------------------------------------------------------------
   // analog limits, in mV and half-amps
   // ------------------------------------------------------------
   localparam logic [11:0] OVF_MV_5_LO  = 12'h5dc;
   localparam logic [11:0] OVF_MV_5_HI  = 12'h708;
   localparam logic [11:0] OVF_MV_10_LO = 12'h960;
   localparam logic [11:0] OVF_MV_10_HI = 12'hbb8;
   localparam logic [7:0]  ICC_HALF_MAX = 8'h0a;
   localparam logic [6:0]  NOC_HA_00    = 7'h28;
   localparam logic [6:0]  NOC_HA_01    = 7'h1e;
   localparam logic [6:0]  NOC_HA_10    = 7'h18;
   localparam logic [6:0]  NOC_HA_11    = 7'h14;
   localparam logic [1:0]  QUARTER_LAST = 2'h3;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SLEW_FAST, SLEW_SLOW, SLEW_DECAY, SLEW_BUS_CMD, SLEW_SOFT
   } vrc_slew_e;

   typedef enum logic [1:0] {
      RAMP_IDLE = 2'b00, RAMP_UP = 2'b01, RAMP_DN_FAST = 2'b11, RAMP_DN_SLOW = 2'b10
   } vrc_ramp_e;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } vrc_cmd_s;

   typedef struct packed {
      logic       valid;
      logic       ack;
      logic [7:0] rdata;
   } vrc_rsp_s;

   typedef struct packed {
      logic [7:0]  gain_x2;
      logic [9:0]  full_scale_da;
      logic [17:0] lsb_ua;
   } vrc_sense_s;

   typedef struct packed {
      logic [7:0] offset_cfg;
      logic [7:0] sense_cfg;
      logic [7:0] limit_cfg;
      logic [7:0] user_a;
      logic [7:0] user_b;
   } vrc_nvm_s;

   // offset code to 5 mV units
   function automatic logic [2:0] ofs_units(input logic [1:0] code);
      case (code)
         2'h0:    ofs_units = 3'h0;
         2'h1:    ofs_units = 3'h1;
         2'h2:    ofs_units = 3'h2;
         default: ofs_units = 3'h4;
      endcase
   endfunction

   function automatic logic step_is_10mv(input logic [1:0] proto);
      step_is_10mv = (proto == 2'h0) || (proto == 2'h3);
   endfunction

   function automatic vrc_sense_s sense_lookup(input logic [2:0] code);
      case (code)
         3'h0:    sense_lookup = '{8'h19, 10'h0a0, 18'h0f424};
         3'h1:    sense_lookup = '{8'h19, 10'h0d5, 18'h14564};
         3'h2:    sense_lookup = '{8'h32, 10'h0a0, 18'h0f424};
         3'h3:    sense_lookup = '{8'h28, 10'h190, 18'h2625a};
         3'h4:    sense_lookup = '{8'h32, 10'h140, 18'h1e848};
         3'h5:    sense_lookup = '{8'h50, 10'h190, 18'h2625a};
         3'h6:    sense_lookup = '{8'h64, 10'h140, 18'h1e848};
         default: sense_lookup = '{8'h64, 10'h280, 18'h3d090};
      endcase
   endfunction

endpackage

// [verilog/vrc_dac_ramp.sv]
`timescale 1ns/1ns
`default_nettype none
module vrc_dac_ramp (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       new_target,
   input  wire logic [9:0] target_units,
   input  wire logic       offsets_ok,
   input  wire logic [2:0] up_units,
   input  wire logic [2:0] dn_units,
   input  wire logic       slew_tick,
   output var  logic [9:0] dac_q
);

   vrc_pkg::vrc_ramp_e state_q;
   logic [9:0]         count_q;
   logic [9:0]         tgt_q;
   logic [9:0]         thr_q;
   logic [2:0]         off_q;
   logic [1:0]         div_q;
   logic [9:0]         thr_new;

   always_comb begin
      thr_new = target_units + (offsets_ok ? {7'h00, dn_units} : 10'h000);
   end

   // ------------------------------------------------------------
   // ramp engine
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= vrc_pkg::RAMP_IDLE;
         count_q <= 10'h000;
         tgt_q   <= 10'h000;
         thr_q   <= 10'h000;
         off_q   <= 3'h0;
      end else if (new_target) begin
         tgt_q <= target_units;
         thr_q <= thr_new;
         off_q <= 3'h0;
         if (target_units > count_q) begin
            off_q   <= offsets_ok ? up_units : 3'h0;
            state_q <= vrc_pkg::RAMP_UP;
         end else if (target_units < count_q) begin
            state_q <= (thr_new < count_q) ? vrc_pkg::RAMP_DN_FAST : vrc_pkg::RAMP_DN_SLOW;
         end else begin
            state_q <= vrc_pkg::RAMP_IDLE;
         end
      end else if (slew_tick) begin
         case (state_q)
            vrc_pkg::RAMP_UP: begin
               if (count_q + 10'h001 >= tgt_q) begin
                  count_q <= tgt_q;
                  off_q   <= 3'h0;
                  state_q <= vrc_pkg::RAMP_IDLE;
               end else begin
                  count_q <= count_q + 10'h001;
               end
            end
            vrc_pkg::RAMP_DN_FAST: begin
               if (count_q - 10'h001 <= thr_q) begin
                  count_q <= thr_q;
                  state_q <= (thr_q == tgt_q) ? vrc_pkg::RAMP_IDLE : vrc_pkg::RAMP_DN_SLOW;
               end else begin
                  count_q <= count_q - 10'h001;
               end
            end
            vrc_pkg::RAMP_DN_SLOW: begin
               if (div_q == vrc_pkg::QUARTER_LAST) begin
                  count_q <= count_q - 10'h001;
                  if (count_q - 10'h001 <= tgt_q) begin
                     count_q <= tgt_q;
                     state_q <= vrc_pkg::RAMP_IDLE;
                  end
               end
            end
            default: state_q <= vrc_pkg::RAMP_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // quarter-rate divider
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_q <= 2'h0;
      end else if (new_target || state_q != vrc_pkg::RAMP_DN_SLOW) begin
         div_q <= 2'h0;
      end else if (slew_tick) begin
         div_q <= div_q + 2'h1;
      end
   end

   // registered output, one cycle behind count
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dac_q <= 10'h000;
      end else begin
         dac_q <= count_q + {7'h00, off_q};
      end
   end

endmodule
`default_nettype wire

// [verilog/vrc_reg_bank.sv]
`timescale 1ns/1ns
`default_nettype none
module vrc_reg_bank (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic               cmd_valid,
   input  wire vrc_pkg::vrc_cmd_s  cmd,
   output var  vrc_pkg::vrc_rsp_s  rsp_q,
   input  wire logic               nvm_load,
   input  wire vrc_pkg::vrc_nvm_s  nvm_image,
   output var  vrc_pkg::vrc_nvm_s  nvm_shadow_q,
   input  wire logic               new_target,
   input  wire logic [7:0]         voltage_target_code,
   input  wire vrc_pkg::vrc_slew_e slew_mode,
   input  wire logic               slew_tick,
   input  wire logic [1:0]         voltage_step_protocol_select,
   input  wire logic [7:0]         max_current_setting,
   input  wire logic [11:0]        vout_mv,
   input  wire logic [7:0]         bus_status_one,
   output var  logic [9:0]         dac_units_q,
   output var  logic               unlocked_q,
   output var  logic               overvoltage_fault_q,
   output var  logic               high_side_off_q,
   output var  logic               low_side_on_q,
   output var  logic [11:0]        ovf_threshold_mv_q,
   output var  logic [6:0]         noc_limit_half_amps_q,
   output var  vrc_pkg::vrc_sense_s input_sense_q,
   output var  logic [7:0]         bus_status_one_mirror_q
);

   logic       wr_req;
   logic       rd_req;
   logic       guarded_hit;
   logic       wr_accept;
   logic [7:0] rd_data;
   logic [1:0] seq_q;
   logic [7:0] expect_code;
   logic       step10;
   logic       offsets_ok;
   logic [9:0] target_units;
   logic [11:0] ovf_thr;
   logic       ovf_armed;
   logic       fault_clear_command;

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   always_comb begin
      wr_req = cmd_valid && cmd.wr;
      rd_req = cmd_valid && !cmd.wr;
      guarded_hit = (cmd.addr == vrc_pkg::ADDR_OFFSET_CFG) || (cmd.addr == vrc_pkg::ADDR_SENSE_CFG)
                 || (cmd.addr == vrc_pkg::ADDR_LIMIT_CFG) || (cmd.addr == vrc_pkg::ADDR_USER_A)
                 || (cmd.addr == vrc_pkg::ADDR_USER_B);
      wr_accept = wr_req && guarded_hit && unlocked_q;
      fault_clear_command = wr_req && (cmd.addr == vrc_pkg::ADDR_FAULT_CLEAR_COMMAND);
   end

   always_comb begin
      case (cmd.addr)
         vrc_pkg::ADDR_OFFSET_CFG: rd_data = nvm_shadow_q.offset_cfg;
         vrc_pkg::ADDR_SENSE_CFG:  rd_data = nvm_shadow_q.sense_cfg;
         vrc_pkg::ADDR_LIMIT_CFG:  rd_data = nvm_shadow_q.limit_cfg;
         vrc_pkg::ADDR_USER_A:     rd_data = nvm_shadow_q.user_a;
         vrc_pkg::ADDR_USER_B:     rd_data = nvm_shadow_q.user_b;
         vrc_pkg::ADDR_MIRROR:     rd_data = bus_status_one_mirror_q;
         default:                  rd_data = vrc_pkg::RESET_REG;
      endcase
   end

   // ------------------------------------------------------------
   // response
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_q <= '0;
      end else begin
         rsp_q.valid <= cmd_valid;
         rsp_q.ack   <= rd_req || wr_accept || fault_clear_command;
         rsp_q.rdata <= rd_req ? rd_data : vrc_pkg::RESET_REG;
      end
   end

   // ------------------------------------------------------------
   // write lock
   // ------------------------------------------------------------
   always_comb begin
      case (seq_q)
         2'h0:    expect_code = vrc_pkg::PASS_CODE0;
         2'h1:    expect_code = vrc_pkg::PASS_CODE1;
         default: expect_code = vrc_pkg::PASS_CODE2;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         unlocked_q <= 1'b0;
         seq_q      <= 2'h0;
      end else if (wr_req && cmd.addr == vrc_pkg::ADDR_LOCK) begin
         if (unlocked_q) begin
            unlocked_q <= 1'b0;
            seq_q      <= 2'h0;
         end else if (cmd.wdata == expect_code) begin
            if (seq_q == vrc_pkg::PASS_LAST) begin
               unlocked_q <= 1'b1;
               seq_q      <= 2'h0;
            end else begin
               seq_q <= seq_q + 2'h1;
            end
         end else begin
            seq_q <= 2'h0;
         end
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   // nvm_load serves both power-up recall and restore of user defaults
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         nvm_shadow_q <= '0;
      end else if (nvm_load) begin
         nvm_shadow_q.offset_cfg <= nvm_image.offset_cfg & vrc_pkg::MASK_OFFSET_CFG;
         nvm_shadow_q.sense_cfg  <= nvm_image.sense_cfg & vrc_pkg::MASK_SENSE_CFG;
         nvm_shadow_q.limit_cfg  <= nvm_image.limit_cfg & vrc_pkg::MASK_LIMIT_CFG;
         nvm_shadow_q.user_a     <= nvm_image.user_a & vrc_pkg::MASK_USER_A;
         nvm_shadow_q.user_b     <= nvm_image.user_b & vrc_pkg::MASK_USER_B;
      end else if (wr_accept) begin
         // user fields keep upper bits only
         case (cmd.addr)
            vrc_pkg::ADDR_OFFSET_CFG: nvm_shadow_q.offset_cfg <= cmd.wdata & vrc_pkg::MASK_OFFSET_CFG;
            vrc_pkg::ADDR_SENSE_CFG:  nvm_shadow_q.sense_cfg  <= cmd.wdata & vrc_pkg::MASK_SENSE_CFG;
            vrc_pkg::ADDR_LIMIT_CFG:  nvm_shadow_q.limit_cfg  <= cmd.wdata & vrc_pkg::MASK_LIMIT_CFG;
            vrc_pkg::ADDR_USER_A:     nvm_shadow_q.user_a     <= cmd.wdata & vrc_pkg::MASK_USER_A;
            default:                  nvm_shadow_q.user_b     <= cmd.wdata & vrc_pkg::MASK_USER_B;
         endcase
      end
   end

   // ------------------------------------------------------------
   // transition offsets and dac ramp
   // ------------------------------------------------------------
   always_comb begin
      step10 = vrc_pkg::step_is_10mv(voltage_step_protocol_select);
      target_units = step10 ? {voltage_target_code, 1'b0} : {2'h0, voltage_target_code};
      offsets_ok = (slew_mode == vrc_pkg::SLEW_FAST) || (slew_mode == vrc_pkg::SLEW_SLOW);
   end

   vrc_dac_ramp u_ramp (
      .clk          (clk),
      .reset_n      (reset_n),
      .new_target   (new_target),
      .target_units (target_units),
      .offsets_ok   (offsets_ok),
      .up_units     (vrc_pkg::ofs_units(nvm_shadow_q.offset_cfg[vrc_pkg::OFS_UP_LSB +: 2])),
      .dn_units     (vrc_pkg::ofs_units(nvm_shadow_q.offset_cfg[vrc_pkg::OFS_DN_LSB +: 2])),
      .slew_tick    (slew_tick),
      .dac_q        (dac_units_q)
   );

   // ------------------------------------------------------------
   // fixed overvoltage
   // ------------------------------------------------------------
   always_comb begin
      case ({step10, nvm_shadow_q.limit_cfg[vrc_pkg::OVF_SEL_BIT]})
         2'b00:   ovf_thr = vrc_pkg::OVF_MV_5_LO;
         2'b01:   ovf_thr = vrc_pkg::OVF_MV_5_HI;
         2'b10:   ovf_thr = vrc_pkg::OVF_MV_10_LO;
         default: ovf_thr = vrc_pkg::OVF_MV_10_HI;
      endcase
      // armed from reset, no enable needed
      ovf_armed = !nvm_shadow_q.limit_cfg[vrc_pkg::OVF_DIS_BIT];
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ovf_threshold_mv_q <= vrc_pkg::OVF_MV_5_LO;
      end else begin
         ovf_threshold_mv_q <= ovf_thr;
      end
   end

   // set wins over fault_clear_command in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         overvoltage_fault_q <= 1'b0;
         high_side_off_q     <= 1'b0;
         low_side_on_q       <= 1'b0;
      end else if (ovf_armed && vout_mv > ovf_thr) begin
         overvoltage_fault_q <= 1'b1;
         high_side_off_q     <= 1'b1;
         low_side_on_q       <= 1'b1;
      end else if (fault_clear_command) begin
         overvoltage_fault_q <= 1'b0;
         high_side_off_q     <= 1'b0;
         low_side_on_q       <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // current limits and input sense
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         noc_limit_half_amps_q <= vrc_pkg::NOC_HA_00;
      end else begin
         case (nvm_shadow_q.limit_cfg[vrc_pkg::NOC_SEL_LSB +: 2])
            2'h0:    noc_limit_half_amps_q <= (max_current_setting <= vrc_pkg::ICC_HALF_MAX)
                                              ? (vrc_pkg::NOC_HA_00 >> 1) : vrc_pkg::NOC_HA_00;
            2'h1:    noc_limit_half_amps_q <= (max_current_setting <= vrc_pkg::ICC_HALF_MAX)
                                              ? (vrc_pkg::NOC_HA_01 >> 1) : vrc_pkg::NOC_HA_01;
            2'h2:    noc_limit_half_amps_q <= (max_current_setting <= vrc_pkg::ICC_HALF_MAX)
                                              ? (vrc_pkg::NOC_HA_10 >> 1) : vrc_pkg::NOC_HA_10;
            default: noc_limit_half_amps_q <= (max_current_setting <= vrc_pkg::ICC_HALF_MAX)
                                              ? (vrc_pkg::NOC_HA_11 >> 1) : vrc_pkg::NOC_HA_11;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         input_sense_q <= vrc_pkg::sense_lookup(3'h0);
      end else begin
         input_sense_q <= vrc_pkg::sense_lookup(nvm_shadow_q.sense_cfg[2:0]);
      end
   end

   // ------------------------------------------------------------
   // status mirror
   // ------------------------------------------------------------
   // no write path: bus clears show up one cycle later
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_status_one_mirror_q <= vrc_pkg::RESET_REG;
      end else begin
         bus_status_one_mirror_q <= bus_status_one & vrc_pkg::MASK_MIRROR;
      end
   end

endmodule
`default_nettype wire

// [dv/vrc_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module vrc_monitor (
   input wire logic              clk,
   input wire logic              reset_n,
   input wire logic              cmd_valid,
   input wire vrc_pkg::vrc_cmd_s cmd,
   input wire vrc_pkg::vrc_rsp_s rsp_q,
   input wire logic              nvm_load,
   input wire logic              unlocked_q,
   input wire logic              overvoltage_fault_q,
   input wire logic              high_side_off_q,
   input wire logic              low_side_on_q,
   input wire logic [7:0]        bus_status_one,
   input wire logic [7:0]        bus_status_one_mirror_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   read_ack_a: assert property (cmd_valid && !cmd.wr |=> rsp_q.valid && rsp_q.ack)
      else $error("read not answered with ack");
   lock_nack_a: assert property (cmd_valid && cmd.wr && cmd.addr == 8'hb1 |=> rsp_q.valid && !rsp_q.ack)
      else $error("lock write acked");
   locked_nack_a: assert property (cmd_valid && cmd.wr && !unlocked_q && cmd.addr inside {8'hb0, 8'hb3, 8'hb4,
      8'hb5, 8'hb6} |=> !rsp_q.ack)
      else $error("protected write acked while locked");
   open_ack_a: assert property (cmd_valid && cmd.wr && unlocked_q && cmd.addr inside {8'hb0, 8'hb3, 8'hb4,
      8'hb5, 8'hb6} |=> rsp_q.ack)
      else $error("write refused while unlocked");
   relock_a: assert property (cmd_valid && cmd.wr && cmd.addr == 8'hb1 && unlocked_q |=> !unlocked_q)
      else $error("lock write did not relock");
   restore_keep_a: assert property (nvm_load && !cmd_valid |=> $stable(unlocked_q))
      else $error("recall changed lock state");
   mirror_copy_a: assert property (1'b1 |=> bus_status_one_mirror_q == ($past(bus_status_one) & 8'h8f))
      else $error("status mirror differs");
   latch_pair_a: assert property (overvoltage_fault_q |-> high_side_off_q && low_side_on_q)
      else $error("fault without switch latch");
endmodule
`default_nettype wire

// [dv/vrc_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module vrc_host_model (
   input  wire logic              clk,
   output var  logic              cmd_valid,
   output var  vrc_pkg::vrc_cmd_s cmd,
   input  wire vrc_pkg::vrc_rsp_s rsp_q
);
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output vrc_pkg::vrc_rsp_s r);
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd = '{w, a, d};
      @(posedge clk);
      #1;
      r = rsp_q;
      cmd_valid = 1'b0;
      // released lines never hold the old byte
      cmd = ~cmd;
   endtask
endmodule
`default_nettype wire

// [dv/test_vr_config_lock_register_bank.sv]
`timescale 1ns/1ns
`default_nettype none
module test_vr_config_lock_register_bank;
   logic                clk, reset_n, nvm_load, new_target, slew_tick, cmd_valid;
   logic                unlocked_q, overvoltage_fault_q, high_side_off_q, low_side_on_q;
   logic [1:0]          voltage_step_protocol_select;
   logic [7:0]          voltage_target_code, max_current_setting, bus_status_one, bus_status_one_mirror_q;
   logic [9:0]          dac_units_q;
   logic [11:0]         vout_mv, ovf_threshold_mv_q;
   logic [6:0]          noc_limit_half_amps_q;
   vrc_pkg::vrc_slew_e  slew_mode;
   vrc_pkg::vrc_cmd_s   cmd;
   vrc_pkg::vrc_rsp_s   rsp_q;
   vrc_pkg::vrc_sense_s input_sense_q;
   int                  mismatches, compares;
   vrc_host_model host (.clk, .cmd_valid, .cmd, .rsp_q);
   vrc_reg_bank DUT (.clk, .reset_n, .cmd_valid, .cmd, .rsp_q, .nvm_load, .nvm_image('0), .nvm_shadow_q(),
      .new_target, .voltage_target_code, .slew_mode, .slew_tick, .voltage_step_protocol_select,
      .max_current_setting, .vout_mv, .bus_status_one, .dac_units_q, .unlocked_q, .overvoltage_fault_q,
      .high_side_off_q, .low_side_on_q, .ovf_threshold_mv_q, .noc_limit_half_amps_q, .input_sense_q,
      .bus_status_one_mirror_q);
   always #50 clk = ~clk;
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic k);
      vrc_pkg::vrc_rsp_s r;
      host.xfer(1'b1, a, d, r);
      chk("write answer", {16'h0, 1'b1, k}, {16'h0, r.valid, r.ack});
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      vrc_pkg::vrc_rsp_s r;
      host.xfer(1'b0, a, 8'h00, r);
      chk("read answer", {8'h3, e}, {8'h0, r.valid, r.ack, r.rdata});
   endtask
   task automatic unlock;
      wr(8'hb1, vrc_pkg::PASS_CODE0, 1'b0);
      wr(8'hb1, vrc_pkg::PASS_CODE1, 1'b0);
      wr(8'hb1, vrc_pkg::PASS_CODE2, 1'b0);
   endtask
   task automatic conclude;
      if (mismatches == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_lock;
      logic [7:0] s [4] = '{vrc_pkg::PASS_CODE0, 8'h00, vrc_pkg::PASS_CODE1, vrc_pkg::PASS_CODE2};
      chk("thr", 18'h5dc, {6'h0, ovf_threshold_mv_q});
      wr(8'hb4, 8'h08, 1'b0);
      rd(8'hb4, 8'h00);
      foreach (s[i]) wr(8'hb1, s[i], 1'b0);
      chk("lock", 18'h0, {17'h0, unlocked_q});
      unlock();
      chk("lock", 18'h1, {17'h0, unlocked_q});
   endtask
   task automatic t_regs;
      logic [7:0] a [5] = '{8'hb0, 8'hb3, 8'hb4, 8'hb5, 8'hb6};
      logic [7:0] m [5] = '{8'h0f, 8'h07, 8'h0f, 8'hf0, 8'he0};
      foreach (a[i]) begin
         wr(a[i], 8'hff, 1'b1);
         rd(a[i], m[i]);
      end
      wr(8'hba, 8'h00, 1'b0);
      rd(8'hba, 8'h8f);
      rd(8'hc5, 8'h00);
   endtask
   task automatic t_limits;
      logic [6:0] h [4] = '{7'h28, 7'h1e, 7'h18, 7'h14};
      for (int c = 0; c < 8; c++) begin
         max_current_setting = (c < 4) ? 8'h0f : 8'h0a;
         wr(8'hb4, {6'h0, c[1:0]}, 1'b1);
         step(1);
         chk("noc", {11'h0, (c < 4) ? h[c[1:0]] : h[c[1:0]] >> 1}, {11'h0, noc_limit_half_amps_q});
      end
      wr(8'hb4, 8'h08, 1'b1);
      step(1);
      chk("thr", 18'h708, {6'h0, ovf_threshold_mv_q});
      voltage_step_protocol_select = 2'h0;
      step(1);
      chk("thr", 18'hbb8, {6'h0, ovf_threshold_mv_q});
      voltage_step_protocol_select = 2'h1;
   endtask
   task automatic t_ovf;
      vout_mv = 12'h76c;
      step(2);
      chk("ovf", 18'h7, {15'h0, overvoltage_fault_q, high_side_off_q, low_side_on_q});
      wr(8'h03, 8'h00, 1'b1);
      chk("ovf", 18'h7, {15'h0, overvoltage_fault_q, high_side_off_q, low_side_on_q});
      vout_mv = 12'h3e8;
      wr(8'h03, 8'h00, 1'b1);
      step(1);
      chk("ovf", 18'h0, {15'h0, overvoltage_fault_q, high_side_off_q, low_side_on_q});
      wr(8'hb4, 8'h0c, 1'b1);
      vout_mv = 12'h76c;
      step(3);
      chk("ovf", 18'h0, {17'h0, overvoltage_fault_q});
      vout_mv = 12'h000;
      wr(8'hb3, 8'h07, 1'b1);
      step(1);
      chk("sense", 18'h3d090, input_sense_q.lsb_ua);
      chk("gain", 18'h64, {10'h0, input_sense_q.gain_x2});
   endtask
   task automatic ramp(input vrc_pkg::vrc_slew_e m, input logic [7:0] t);
      slew_mode = m;
      voltage_target_code = t;
      new_target = 1'b1;
      step(1);
      new_target = 1'b0;
      step(1);
   endtask
   task automatic t_ramp;
      wr(8'hb0, 8'h01, 1'b1);
      ramp(vrc_pkg::SLEW_FAST, 8'h03);
      chk("dac", 18'h1, {8'h0, dac_units_q});
      slew_tick = 1'b1;
      step(3);
      slew_tick = 1'b0;
      step(2);
      chk("dac", 18'h3, {8'h0, dac_units_q});
      ramp(vrc_pkg::SLEW_BUS_CMD, 8'h06);
      chk("dac", 18'h3, {8'h0, dac_units_q});
      // one tick: an offset wrongly applied would show as 5
      slew_tick = 1'b1;
      step(1);
      slew_tick = 1'b0;
      step(1);
      chk("dac", 18'h4, {8'h0, dac_units_q});
      // down code 2 is two units: fast to 2, then quarter rate
      wr(8'hb0, 8'h08, 1'b1);
      ramp(vrc_pkg::SLEW_FAST, 8'h00);
      slew_tick = 1'b1;
      step(5);
      slew_tick = 1'b0;
      step(1);
      chk("dac", 18'h2, {8'h0, dac_units_q});
      slew_tick = 1'b1;
      step(1);
      slew_tick = 1'b0;
      step(1);
      chk("dac", 18'h1, {8'h0, dac_units_q});
      nvm_load = 1'b1;
      step(1);
      nvm_load = 1'b0;
      chk("lock", 18'h1, {17'h0, unlocked_q});
      wr(8'hb1, vrc_pkg::PASS_CODE0, 1'b0);
      wr(8'hb5, 8'h10, 1'b0);
   endtask
   initial begin
      {clk, reset_n, nvm_load, new_target, slew_tick} = '0;
      {voltage_target_code, vout_mv} = '0;
      slew_mode = vrc_pkg::SLEW_FAST;
      voltage_step_protocol_select = 2'h1;
      max_current_setting = 8'h0f;
      bus_status_one = 8'hff;
      step(6);
      reset_n = 1'b1;
      t_lock();
      t_regs();
      t_limits();
      t_ovf();
      t_ramp();
      conclude();
   end
   // hang guard well beyond the roughly 125 cycles used
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end
endmodule
bind vrc_reg_bank vrc_monitor mon (.clk, .reset_n, .cmd_valid, .cmd, .rsp_q, .nvm_load, .unlocked_q,
   .overvoltage_fault_q, .high_side_off_q, .low_side_on_q, .bus_status_one, .bus_status_one_mirror_q);
`default_nettype wire
